/* tmr_core.sv */
// 16-bit timer mode engine: normal, clear-on-match and fast PWM
//
// Overview of operation
// [RL1] Mode 0 counts up, wraps 0xFFFF to 0
// [RL2] Free-running overflow flag set as count zeroes
// [RL3] Hardware only sets overflow; handler entry clears
// [RL4] Free-running count accepts writes any time
// [RL5] Clear-on-match resets at compare A or capture
// [RL6] Unbuffered TOP; low TOP wraps through 0xFFFF
// [RL7] Clear-on-match sets TOP register's flag
// [RL8] Toggle action inverts output every match; in fast PWM only unit A in mode 15
// [RL9] Clear-on-match overflow set on 0xFFFF rollover
// [RL10] Fast PWM modes 5,6,7,14,15 pick TOP
// [RL11] Fast PWM clears one cycle after TOP
// [RL12] Action 2 non-inverted, 3 inverted PWM; here 2 sets at match and clears at TOP, 3 the reverse
// [RL13] Fast PWM overflow and TOP flag at TOP
// [RL14] Each unit flags on its compare match
// [RL15] Fixed TOP masks compare bits on write
// [RL16] Capture TOP written directly, may wrap
// [RL17] Compare A buffered, loaded at TOP
// [RL18] Zero gives spike, TOP gives constant
// [RL19] Mode 15 toggle gives square wave
// [RL20] Pin driven only when direction is output
// [RL21] Software keeps register TOP at least 0x0003
// [RL22] Software keeps TOP above compare values
// [RL23] Action 0 leaves waveform bit unchanged
// [RL24] Count write blocks next-tick compare match
// [RL25] Compare buffering only in PWM modes
// [RL26] Other modes handed to dual-slope hook
// [RL27] Everything advances only on timer tick
module tmr_core
    import tmr_pkg::*;
#(
    parameter int N_UNITS = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Timer tick from prescaler
    input wire logic timer_tick,
    // Mode controls
    input wire logic [3:0] waveform_mode_select,
    input wire logic [2*N_UNITS-1:0] output_action_select,
    input wire logic [N_UNITS-1:0] pin_direction_bit,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Overflow handler acknowledge
    input wire logic overflow_ack,
    // Flags
    output logic overflow_flag,
    output logic capture_flag,
    output logic [N_UNITS-1:0] compare_flag,
    // Pins
    output logic [N_UNITS-1:0] wave_output,
    output logic [N_UNITS-1:0] wave_pin_out,
    output logic [N_UNITS-1:0] wave_pin_oe,
    // Dual-slope sequencer hook
    output logic dual_slope_sel,
    output logic [15:0] hook_count
);
    import tmr_pkg::*;

    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_CAPTURE = 4'h1;
    localparam logic [3:0] ADDR_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_CMP0 = 4'h4;
    localparam logic [3:0] ADDR_BUF0 = 4'h8;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] icr;
        logic block;
        logic tov;
        logic icf;
        logic [N_UNITS-1:0] ocf;
        logic [15:0] rdata;
    } tmr_core_t;
    tmr_core_t s_q;
    tmr_core_t s_d;

    tmr_mode_t mode;
    logic [15:0] top;
    logic [15:0] res_mask;
    logic cmpa_top;
    logic cap_top;
    logic at_top;
    logic top_hit;
    logic cnt_wr;
    logic [15:0] cmp_act [N_UNITS];
    logic [15:0] cmp_buf [N_UNITS];
    logic [N_UNITS-1:0] unit_match;
    logic [N_UNITS-1:0] unit_flag;
    logic [N_UNITS-1:0] unit_wr;

    // [RL10] Mode decode and TOP selection
    always_comb begin
        mode = TMR_OTHER;
        top = CNT_MAX;
        res_mask = CNT_MAX;
        cmpa_top = 1'b0;
        cap_top = 1'b0;
        case (waveform_mode_select)
            WGM_NORMAL: mode = TMR_NORMAL;
            WGM_CTC_CMPA: begin
                mode = TMR_CTC;
                top = cmp_act[0];
                cmpa_top = 1'b1;
            end
            WGM_CTC_CAP: begin
                mode = TMR_CTC;
                top = s_q.icr;
                cap_top = 1'b1;
            end
            WGM_FAST_8: begin
                mode = TMR_FAST;
                top = TOP_8BIT;
                res_mask = TOP_8BIT;
            end
            WGM_FAST_9: begin
                mode = TMR_FAST;
                top = TOP_9BIT;
                res_mask = TOP_9BIT;
            end
            WGM_FAST_10: begin
                mode = TMR_FAST;
                top = TOP_10BIT;
                res_mask = TOP_10BIT;
            end
            WGM_FAST_CAP: begin
                mode = TMR_FAST;
                top = s_q.icr;
                cap_top = 1'b1;
            end
            WGM_FAST_CMPA: begin
                mode = TMR_FAST;
                top = cmp_act[0];
                cmpa_top = 1'b1;
            end
            default: mode = TMR_OTHER;
        endcase
    end

    // [RL26] Unsupported modes go to external sequencer
    assign dual_slope_sel = (mode == TMR_OTHER);
    assign hook_count = s_q.cnt;

    assign cnt_wr = reg_wr && (reg_addr == ADDR_COUNT);
    // [RL6] Exact equality, so low TOP wraps first
    // [RL16] Capture TOP compared directly
    // Top match obeys the same write block as compare units
    assign at_top = (s_q.cnt == top) && !s_q.block;
    assign top_hit = timer_tick && at_top && (mode == TMR_CTC || mode == TMR_FAST);

    genvar gi;
    generate
        for (gi = 0; gi < N_UNITS; gi++) begin : g_unit
            assign unit_wr[gi] = reg_wr && (reg_addr == ADDR_CMP0 + 4'(gi));
            tmr_wave_unit #(.W(16)) u_unit (
                .ref_clk(ref_clk),
                .srst(srst),
                .tick(timer_tick),
                .mode(mode),
                .count(s_q.cnt),
                .res_mask(res_mask),
                .at_top(at_top && !dual_slope_sel),
                .block_match(s_q.block),
                .action(output_action_select[2*gi+:2]),
                .is_unit_a(gi == 0),
                .cmpa_top(cmpa_top),
                .wr(unit_wr[gi]),
                .wr_data(reg_wdata),
                .active_value(cmp_act[gi]),
                .buffer_value(cmp_buf[gi]),
                .match(unit_match[gi]),
                .wave(wave_output[gi]),
                .flag_set(unit_flag[gi])
            );
            // [RL20] Pin driven only as output
            assign wave_pin_oe[gi] = pin_direction_bit[gi];
            assign wave_pin_out[gi] = wave_output[gi] & pin_direction_bit[gi];
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        // [RL24] Block lasts until next timer tick
        if (timer_tick) begin
            s_d.block = 1'b0;
        end
        // [RL27] Counting only on timer tick
        if (timer_tick && !dual_slope_sel) begin
            // [RL11] Clear on cycle after TOP
            // [RL5] Clear at TOP in clear-on-match
            if (top_hit) begin
                s_d.cnt = CNT_BOTTOM;
            end else begin
                // [RL1] Wrap 0xFFFF to 0
                s_d.cnt = s_q.cnt + 16'h0001;
            end
            // [RL2] Overflow as count becomes zero
            // [RL9] Overflow on rollover
            if (mode != TMR_FAST && s_q.cnt == CNT_MAX) begin
                s_d.tov = 1'b1;
            end
            // [RL13] Fast PWM overflow at TOP
            if (mode == TMR_FAST && top_hit) begin
                s_d.tov = 1'b1;
            end
            // [RL7] Capture flag when it defines TOP
            if (top_hit && cap_top) begin
                s_d.icf = 1'b1;
            end
        end
        // [RL4] Count write at any time
        if (cnt_wr) begin
            s_d.cnt = reg_wdata;
            s_d.block = 1'b1;
        end
        if (reg_wr && reg_addr == ADDR_CAPTURE) begin
            s_d.icr = reg_wdata;
        end
        // Write-one-to-clear; a set in the same cycle wins
        if (reg_wr && reg_addr == ADDR_FLAGS) begin
            s_d.tov = s_q.tov & ~reg_wdata[0];
            s_d.icf = s_q.icf & ~reg_wdata[1];
            s_d.ocf = s_q.ocf & ~reg_wdata[2+:N_UNITS];
        end
        // [RL3] Handler entry clears overflow
        if (overflow_ack) begin
            s_d.tov = 1'b0;
        end
        if (timer_tick && !dual_slope_sel) begin
            if (mode != TMR_FAST && s_q.cnt == CNT_MAX) begin
                s_d.tov = 1'b1;
            end
            if (mode == TMR_FAST && top_hit) begin
                s_d.tov = 1'b1;
            end
            if (top_hit && cap_top) begin
                s_d.icf = 1'b1;
            end
        end
        // [RL14] Compare flags on match
        // [RL7] Compare A top flag follows its match
        s_d.ocf = s_d.ocf | (dual_slope_sel ? '0 : unit_flag);
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == ADDR_COUNT) begin
                s_d.rdata = s_q.cnt;
            end else if (reg_addr == ADDR_CAPTURE) begin
                s_d.rdata = s_q.icr;
            end else if (reg_addr == ADDR_FLAGS) begin
                s_d.rdata = 16'({s_q.ocf, s_q.icf, s_q.tov});
            end else begin
                for (int i = 0; i < N_UNITS; i++) begin
                    if (reg_addr == ADDR_CMP0 + 4'(i)) begin
                        s_d.rdata = cmp_act[i];
                    end
                    if (reg_addr == ADDR_BUF0 + 4'(i)) begin
                        s_d.rdata = cmp_buf[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign overflow_flag = s_q.tov;
    assign capture_flag = s_q.icf;
    assign compare_flag = s_q.ocf;
endmodule : tmr_core

/* tmr_pkg.sv */
// Package of constants and types for the 16-bit timer mode engine
package tmr_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
    localparam logic [3:0] WGM_FAST_8 = 4'h5;
    localparam logic [3:0] WGM_FAST_9 = 4'h6;
    localparam logic [3:0] WGM_FAST_10 = 4'h7;
    localparam logic [3:0] WGM_CTC_CAP = 4'hC;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;
    localparam logic [3:0] WGM_FAST_CMPA = 4'hF;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // Mode class of the counting sequence
    typedef enum logic [3:0] {
        TMR_NORMAL = 4'b0001,
        TMR_CTC = 4'b0010,
        TMR_FAST = 4'b0100,
        TMR_OTHER = 4'b1000
    } tmr_mode_t;
endpackage : tmr_pkg

/* tmr_wave_unit.sv */
// One compare unit: compare register, buffer, match and waveform bit
module tmr_wave_unit
    import tmr_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Control from the counter
    input wire logic tick,
    input wire tmr_pkg::tmr_mode_t mode,
    input wire logic [W-1:0] count,
    input wire logic [W-1:0] res_mask,
    input wire logic at_top,
    input wire logic block_match,
    input wire logic [1:0] action,
    input wire logic is_unit_a,
    input wire logic cmpa_top,
    // Software write
    input wire logic wr,
    input wire logic [W-1:0] wr_data,
    // Results
    output logic [W-1:0] active_value,
    output logic [W-1:0] buffer_value,
    output logic match,
    output logic wave,
    output logic flag_set
);
    typedef struct packed {
        logic [W-1:0] ocr;
        logic [W-1:0] buf_v;
        logic wave;
    } tmr_unit_t;
    tmr_unit_t s_q;
    tmr_unit_t s_d;
    logic cmp_eq;
    logic pwm;

    assign pwm = (mode == TMR_FAST);
    assign cmp_eq = (count == s_q.ocr);
    // [RL24] Match blocked after count write
    assign match = tick && cmp_eq && !block_match;
    // [RL14] Flag on every match
    assign flag_set = match;
    assign active_value = s_q.ocr;
    assign buffer_value = s_q.buf_v;
    assign wave = s_q.wave;

    always_comb begin
        s_d = s_q;
        if (wr) begin
            // [RL25] Buffered only in PWM modes
            // [RL15] Mask bits above fixed resolution
            if (pwm) begin
                s_d.buf_v = wr_data & res_mask;
            end else begin
                s_d.ocr = wr_data;
                s_d.buf_v = wr_data;
            end
        end
        // [RL17] Load active value at TOP
        if (pwm && tick && at_top) begin
            s_d.ocr = s_q.buf_v;
        end
        if (match) begin
            case (action)
                // [RL23] No action leaves wave alone
                ACT_NONE: s_d.wave = s_q.wave;
                // [RL8] Toggle on match
                // [RL19] Fast PWM toggles only unit A with compare A top
                ACT_TOGGLE: begin
                    if (!pwm || (is_unit_a && cmpa_top)) begin
                        s_d.wave = !s_q.wave;
                    end
                end
                // [RL12] Set level at match
                ACT_CLEAR: s_d.wave = pwm ? 1'b1 : 1'b0;
                ACT_SET: s_d.wave = pwm ? 1'b0 : 1'b1;
                default: s_d.wave = s_q.wave;
            endcase
        end
        // [RL12] Opposite level at TOP to zero
        // [RL18] Match at TOP wins for constant level
        if (pwm && tick && at_top && action[1] && !match) begin
            s_d.wave = action[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '{ocr: CMP_RESET, buf_v: CMP_RESET, wave: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
endmodule : tmr_wave_unit

/* tmr_checker.sv */
// Port assertions of the timer mode engine
module tmr_checker
    import tmr_pkg::*;
#(
    parameter int N_UNITS = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Controls
    input wire logic timer_tick,
    input wire logic [3:0] waveform_mode_select,
    input wire logic [2*N_UNITS-1:0] output_action_select,
    input wire logic [N_UNITS-1:0] pin_direction_bit,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic overflow_ack,
    // Results
    input wire logic overflow_flag,
    input wire logic [N_UNITS-1:0] wave_output,
    input wire logic [N_UNITS-1:0] wave_pin_out,
    input wire logic [N_UNITS-1:0] wave_pin_oe,
    input wire logic dual_slope_sel,
    input wire logic [15:0] hook_count
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic blk_q;
    wire cnt_wr = reg_wr && reg_addr == 4'h0;
    // A count write masks matches until the next tick has passed
    always_ff @(posedge ref_clk) begin
        blk_q <= srst ? 1'b0 : (cnt_wr | (blk_q & ~timer_tick));
    end
    sequence s_top(m, t);
        waveform_mode_select == m && timer_tick && !reg_wr && !blk_q && hook_count == t;
    endsequence
    wrap_norm_a: assert property (s_top(WGM_NORMAL, CNT_MAX)
        |=> hook_count == CNT_BOTTOM && overflow_flag) else $error("normal wrap wrong");
    inc_norm_a: assert property (waveform_mode_select == WGM_NORMAL && timer_tick && !reg_wr
        |=> hook_count == $past(hook_count) + 16'h0001) else $error("normal count step wrong");
    ctc_wrap_a: assert property (s_top(WGM_CTC_CMPA, CNT_MAX)
        |=> hook_count == CNT_BOTTOM && overflow_flag) else $error("clear-on-match rollover wrong");
    fast_top_a: assert property (s_top(WGM_FAST_8, TOP_8BIT)
        |=> hook_count == CNT_BOTTOM && overflow_flag) else $error("fast top return wrong");
    count_hold_a: assert property (!timer_tick && !reg_wr |=> $stable(hook_count))
        else $error("count moved without tick");
    mode_hook_a: assert property (dual_slope_sel ==
        !(waveform_mode_select inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF})) else $error("hook select wrong");
    ovf_sticky_a: assert property (overflow_flag && !overflow_ack && !(reg_wr && reg_addr == 4'h2 && reg_wdata[0])
        |=> overflow_flag) else $error("overflow dropped");
    ovf_ack_a: assert property (overflow_ack && !timer_tick |=> !overflow_flag)
        else $error("overflow not cleared");
    pin_drive_a: assert property (wave_pin_oe == pin_direction_bit
        && wave_pin_out == (wave_output & pin_direction_bit)) else $error("pin drive wrong");
    act_none_a: assert property (output_action_select[1:0] == ACT_NONE |=> $stable(wave_output[0]))
        else $error("idle action moved wave");
endmodule : tmr_checker

bind tmr_core tmr_checker #(.N_UNITS(N_UNITS)) u_tmr_checker (.ref_clk, .srst, .timer_tick,
    .waveform_mode_select, .output_action_select, .pin_direction_bit, .reg_addr, .reg_wdata, .reg_wr,
    .overflow_ack, .overflow_flag, .wave_output, .wave_pin_out, .wave_pin_oe, .dual_slope_sel, .hook_count);

/* tmr_pin_model.sv */
// Port pad model seen on the board side of the waveform pins
module tmr_pin_model #(
    parameter int N = 2
) (
    // Clock
    input wire logic ref_clk,
    // Pad drive from the block
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_oe,
    // Level on the wire
    output logic [N-1:0] pin_level
);
    logic [N-1:0] last_q;
    // Floating pad keeps flipping, so a stale level never passes
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ~last_q[i];
        end
    end
    always_ff @(posedge ref_clk) begin
        last_q <= pin_level;
    end
endmodule : tmr_pin_model

/* tmr_core_bench.sv */
// Self-checking bench of the timer mode engine
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t mismatch", $time); end end
module tmr_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tmr_pkg::*;
    logic ref_clk = 0, srst = 1, timer_tick = 0, reg_wr = 0, reg_rd = 0, overflow_ack = 0, pend = 0;
    logic [3:0] waveform_mode_select = 0, reg_addr = 0, output_action_select = 0;
    logic [1:0] pin_direction_bit = 0, compare_flag, wave_output, wave_pin_out, wave_pin_oe, pin_level;
    logic [15:0] reg_wdata = 0, reg_rdata, hook_count, v;
    logic overflow_flag, capture_flag, dual_slope_sel;
    logic [15:0] exp_q[$];
    logic [31:0] rnd = 32'h4768ADB9;
    int n_errors = 0, total_checks = 0, n;
    tmr_core u_tmr_core (.ref_clk, .srst, .timer_tick, .waveform_mode_select, .output_action_select,
        .pin_direction_bit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .overflow_ack, .overflow_flag,
        .capture_flag, .compare_flag, .wave_output, .wave_pin_out, .wave_pin_oe, .dual_slope_sel, .hook_count);
    tmr_pin_model u_tmr_pin_model (.ref_clk, .pin_out(wave_pin_out), .pin_oe(wave_pin_oe), .pin_level);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic ticks(input int k);
        @(posedge ref_clk);
        timer_tick <= 1'b1;
        repeat (k) @(posedge ref_clk);
        timer_tick <= 1'b0;
        @(negedge ref_clk);
    endtask : ticks
    task automatic setm(input logic [3:0] m, input logic [3:0] act);
        @(posedge ref_clk);
        waveform_mode_select <= m;
        output_action_select <= act;
    endtask : setm
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) pend <= reg_rd;
    always @(negedge ref_clk) if (pend) `CHK(reg_rdata, exp_q.pop_front())
    initial begin
        #20000;
        n_errors++;
        results();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rd(4'h2, 16'h0000);
        rd(4'h3, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            setm(i ? WGM_CTC_CMPA : WGM_NORMAL, 4'h0);
            wr(4'h4, 16'h0005);
            wr(4'h0, 16'hFFFE);
            wr(4'h2, 16'h000F);
            ticks(2);
            rd(4'h0, CNT_BOTTOM);
            rd(4'h2, 16'h0001);
        end
        @(posedge ref_clk) overflow_ack <= 1'b1;
        @(posedge ref_clk) overflow_ack <= 1'b0;
        rd(4'h2, 16'h0000);
        setm(WGM_NORMAL, 4'h0);
        v = rnd[15:0];
        wr(4'h0, v);
        n = 0;
        repeat (40) begin
            rnd = lfsr(rnd);
            @(posedge ref_clk) timer_tick <= rnd[0];
            n += rnd[0];
        end
        @(posedge ref_clk) timer_tick <= 1'b0;
        rd(4'h0, v + n[15:0]);
        @(negedge ref_clk);
        `CHK(hook_count, v + n[15:0])
        setm(WGM_CTC_CMPA, 4'h1);
        pin_direction_bit <= 2'b11;
        wr(4'h4, 16'h0003);
        wr(4'h0, 16'h0003);
        wr(4'h2, 16'h000F);
        ticks(1);
        rd(4'h0, 16'h0004);
        wr(4'h0, 16'h0000);
        ticks(6);
        rd(4'h0, 16'h0002);
        rd(4'h2, 16'h000C);
        @(negedge ref_clk);
        `CHK(wave_output[0], 1'b1)
        `CHK(pin_level[0], 1'b1)
        @(posedge ref_clk) pin_direction_bit <= 2'b00;
        @(negedge ref_clk);
        `CHK(wave_pin_out, 2'b00)
        `CHK(wave_pin_oe, 2'b00)
        `CHK(wave_output[0], 1'b1)
        for (int i = 2; i >= 0; i--) begin
            setm(WGM_FAST_8 + i[3:0], 4'h0);
            wr(4'h4, 16'h1234);
            rd(4'h8, 16'h1234 & (i == 2 ? TOP_10BIT : i == 1 ? TOP_9BIT : TOP_8BIT));
        end
        rd(4'h4, 16'h0003);
        wr(4'h0, 16'h00FE);
        wr(4'h2, 16'h000F);
        ticks(2);
        rd(4'h4, 16'h0034);
        rd(4'h0, CNT_BOTTOM);
        rd(4'h2, 16'h0001);
        for (int k = 2; k <= 3; k++) begin
            setm(WGM_NORMAL, 4'h0);
            wr(4'h5, 16'h0080);
            setm(WGM_FAST_8, {k[1:0], 2'b00});
            wr(4'h0, 16'h0000);
            wr(4'h2, 16'h000F);
            ticks(129);
            `CHK(wave_output[1], k == 2)
            `CHK(compare_flag[1], 1'b1)
            ticks(127);
            `CHK(wave_output[1], k != 2)
        end
        // Inverted unit 1 with compare at TOP stays low
        setm(WGM_NORMAL, 4'h0);
        wr(4'h5, TOP_8BIT);
        setm(WGM_FAST_8, 4'hC);
        wr(4'h0, 16'h00FE);
        ticks(2);
        `CHK(wave_output[1], 1'b0)
        ticks(256);
        `CHK(wave_output[1], 1'b0)
        setm(WGM_NORMAL, 4'h0);
        wr(4'h4, 16'h0003);
        wr(4'h5, 16'h0002);
        wr(4'h1, 16'h0004);
        setm(WGM_CTC_CAP, 4'h0);
        wr(4'h0, 16'h0000);
        wr(4'h2, 16'h000F);
        ticks(6);
        `CHK(capture_flag, 1'b1)
        rd(4'h0, 16'h0001);
        rd(4'h2, 16'h000E);
        setm(WGM_FAST_CAP, 4'h0);
        wr(4'h0, 16'hFFFE);
        wr(4'h2, 16'h000F);
        ticks(2);
        rd(4'h0, CNT_BOTTOM);
        rd(4'h2, 16'h0000);
        ticks(5);
        `CHK(capture_flag, 1'b1)
        `CHK(overflow_flag, 1'b1)
        rd(4'h2, 16'h000F);
        setm(WGM_FAST_CMPA, 4'h1);
        wr(4'h4, 16'h0005);
        wr(4'h0, 16'h0002);
        ticks(2);
        `CHK(wave_output[0], 1'b0)
        rd(4'h4, 16'h0005);
        ticks(5);
        `CHK(wave_output[0], 1'b0)
        ticks(1);
        `CHK(wave_output[0], 1'b1)
        setm(4'h1, 4'h0);
        ticks(3);
        `CHK(dual_slope_sel, 1'b1)
        results();
    end
endmodule : tmr_core_bench
